// ### bench/uarx_far_tx.sv
`timescale 1ns/1ns
// remote serial transmitter: start bit, data lsb first, two stop bits
module uarx_far_tx (
    input  wire logic       core_clk,
    input  wire logic       start,
    input  wire logic [8:0] data,
    input  wire logic [3:0] nbits,
    input  wire logic       stop1,
    input  wire logic [7:0] bit_clks,
    input  wire logic       rts_n_full,
    output logic            txd,
    output logic            busy
);
    int i;

    // hold each level for one bit period; rate set by bit_clks
    task automatic put(input logic b);
        txd <= b;
        repeat (bit_clks) @(posedge core_clk);
    endtask

    // one frame per start request; idle line stays high
    initial begin
        txd = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge core_clk);
            if (start === 1'b1) begin
                busy <= 1'b1;
                // hold off while the receiver reports full
                while (rts_n_full === 1'b1) @(posedge core_clk);
                put(1'b0);
                // ninth data bit carries the frame type
                for (i = 0; i < nbits; i++) put(data[i]);
                // first stop bit may carry the frame type
                put(stop1);
                put(1'b1);
                busy <= 1'b0;
            end
        end
    end
endmodule

// ### bench/uarx_top_tb.sv
`timescale 1ns/1ns
module uarx_top_tb;
    import uarx_pkg::*;
    logic        core_clk = 1'b0;
    logic        resetn, hsel, hwrite, hreadyout, hresp;
    logic        rxd, tx_done_evt, rts_n_full, start, stop1, busy;
    logic [7:0]  haddr, bit_clks;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, r;
    logic [8:0]  data;
    logic [3:0]  nbits;
    int          errors, checks, i;

    always #10 core_clk = ~core_clk;

    uarx_top dut (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd),
        .tx_done_evt(tx_done_evt), .rts_n_full(rts_n_full));

    uarx_far_tx far (.core_clk(core_clk), .start(start), .data(data),
        .nbits(nbits), .stop1(stop1), .bit_clks(bit_clks),
        .rts_n_full(rts_n_full), .txd(rxd), .busy(busy));

    // single word transfer; waits on hreadyout in both phases
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic bit_is(input logic [7:0] a, input int k, input logic v);
        ahb(a, 1'b0, 32'h0);
        chk({31'h0, r[k]}, {31'h0, v});
    endtask

    // pops one character and compares its low byte
    task automatic data_is(input logic [7:0] v);
        ahb(OFS_SERIAL_DATA, 1'b0, 32'h0);
        chk({24'h0, r[7:0]}, {24'h0, v});
    endtask

    // far side sends one frame; returns once its line is idle again
    task automatic frame(input logic [8:0] d, input logic [3:0] n,
                         input logic s);
        data <= d;
        nbits <= n;
        stop1 <= s;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        @(posedge core_clk);
        while (busy === 1'b1) @(posedge core_clk);
    endtask

    task automatic results;
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // generous bound: the whole run is well under this
    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        results;
    end

    initial begin
        resetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; start = 1'b0;
        data = 9'h000; nbits = 4'h8; stop1 = 1'b1; bit_clks = 8'h20;
        tx_done_evt = 1'b0; errors = 0; checks = 0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        ahb(OFS_BAUD_DIVISOR, 1'b0, 32'h0);
        chk(r, {20'h0, BAUD_RESET});
        chk({31'h0, hresp}, 32'h0);
        // unmapped place reads zero and ignores writes
        wr(8'h20, 32'hffffffff);
        ahb(8'h20, 1'b0, 32'h0);
        chk(r, 32'h0);
        // tick every 2 clocks: 32 clocks a bit, 16 in double speed
        wr(OFS_BAUD_DIVISOR, 32'h1);
        // nine-bit frames with the address filter on, then off
        wr(OFS_CTRL_B, 32'h14);
        wr(OFS_CTRL_C, 32'h06);
        wr(OFS_CTRL_STATUS_A, 32'h01);
        frame(9'h0a5, 4'h9, 1'b1);
        bit_is(OFS_CTRL_STATUS_A, RXC_BIT, 1'b0);
        frame(9'h15a, 4'h9, 1'b1);
        bit_is(OFS_CTRL_STATUS_A, RXC_BIT, 1'b1);
        bit_is(OFS_CTRL_B, RX9_BIT, 1'b1);
        data_is(8'h5a);
        wr(OFS_CTRL_STATUS_A, 32'h00);
        frame(9'h033, 4'h9, 1'b1);
        bit_is(OFS_CTRL_B, RX9_BIT, 1'b0);
        data_is(8'h33);
        // eight-bit frames: first stop bit marks the type
        wr(OFS_CTRL_B, 32'h10);
        wr(OFS_CTRL_C, 32'h0e);
        wr(OFS_CTRL_STATUS_A, 32'h01);
        frame(9'h0c3, 4'h8, 1'b0);
        bit_is(OFS_CTRL_STATUS_A, RXC_BIT, 1'b0);
        frame(9'h03c, 4'h8, 1'b1);
        data_is(8'h3c);
        // off-nominal rates in normal speed, then double speed
        for (i = 0; i < 3; i++) begin
            wr(OFS_CTRL_STATUS_A, (i == 2) ? 32'h02 : 32'h00);
            bit_clks <= (i == 0) ? 8'd31 : (i == 1) ? 8'd33 : 8'd16;
            frame(9'h081 + 9'(i), 4'h8, 1'b1);
            data_is(8'h81 + 8'(i));
        end
        bit_clks <= 8'd32;
        wr(OFS_CTRL_STATUS_A, 32'h00);
        // even parity: wrong parity bit and a low first stop bit
        wr(OFS_CTRL_C, 32'h2e);
        frame(9'h155, 4'h9, 1'b0);
        bit_is(OFS_CTRL_STATUS_A, PE_BIT, 1'b1);
        bit_is(OFS_CTRL_STATUS_A, FE_BIT, 1'b1);
        data_is(8'h55);
        wr(OFS_CTRL_C, 32'h0e);
        // four frames unread, flow off: the fourth replaces the waiting one
        for (i = 0; i < 4; i++) frame(9'h010 + 9'(i), 4'h8, 1'b1);
        chk({31'h0, rts_n_full}, 32'h0);
        bit_is(OFS_CTRL_STATUS_A, DOR_BIT, 1'b1);
        data_is(8'h10);
        data_is(8'h11);
        data_is(8'h13);
        bit_is(OFS_CTRL_STATUS_A, RXC_BIT, 1'b0);
        // flow control on: full after two frames, clear after a read
        wr(OFS_CTRL_STATUS_D, 32'h01);
        frame(9'h061, 4'h8, 1'b1);
        chk({31'h0, rts_n_full}, 32'h0);
        frame(9'h062, 4'h8, 1'b1);
        chk({31'h0, rts_n_full}, 32'h1);
        data_is(8'h61);
        repeat (3) @(posedge core_clk);
        chk({31'h0, rts_n_full}, 32'h0);
        data_is(8'h62);
        // transmit-complete flag set by event, cleared by writing one
        tx_done_evt <= 1'b1;
        @(posedge core_clk);
        tx_done_evt <= 1'b0;
        bit_is(OFS_CTRL_STATUS_A, TXC_BIT, 1'b1);
        wr(OFS_CTRL_STATUS_A, 32'h40);
        bit_is(OFS_CTRL_STATUS_A, TXC_BIT, 1'b0);
        results;
    end
endmodule

// ### rtl/uarx_pkg.sv
package uarx_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_STATUS_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B        = 8'h04;
    localparam logic [7:0] OFS_CTRL_C        = 8'h08;
    localparam logic [7:0] OFS_CTRL_STATUS_D = 8'h0c;
    localparam logic [7:0] OFS_SERIAL_DATA   = 8'h10;
    localparam logic [7:0] OFS_BAUD_DIVISOR  = 8'h14;
    // ctrl_status_a bit positions
    localparam int RXC_BIT = 7;
    localparam int TXC_BIT = 6;
    localparam int FE_BIT  = 4;
    localparam int DOR_BIT = 3;
    localparam int PE_BIT  = 2;
    localparam int DSS_BIT = 1;
    localparam int AFE_BIT = 0;
    // ctrl_b bit positions
    localparam int RXEN_BIT = 4;
    localparam int CSZ2_BIT = 2;
    localparam int RX9_BIT  = 1;
    // ctrl_c bit positions
    localparam int PAR_EN_BIT  = 5;
    localparam int PAR_ODD_BIT = 4;
    localparam int TWO_STOP_BIT = 3;
    localparam int CSZ_LO_BIT  = 1;
    // ctrl_status_d bit positions
    localparam int RTS_FLOW_ENABLE_BIT = 0;
    // sampling figures
    localparam logic [4:0] SPB_NORMAL = 5'd16;
    localparam logic [4:0] SPB_DOUBLE = 5'd8;
    localparam logic [4:0] SF_NORMAL  = 5'd8;
    localparam logic [4:0] SF_DOUBLE  = 5'd4;
    localparam logic [4:0] SM_NORMAL  = 5'd9;
    localparam logic [4:0] SM_DOUBLE  = 5'd5;
    localparam logic [2:0] CSZ_NINE   = 3'h7;
    localparam logic [11:0] BAUD_RESET = 12'h000;
    localparam int RX_DEPTH = 2;
endpackage

// ### rtl/uarx_sampler.sv
`timescale 1ns/1ns
// oversampling counter and three-sample majority vote for one bit slot
module uarx_sampler
    import uarx_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic       dbl,
    input  wire logic       rxd,
    output logic            bit_done,
    output logic            bit_val,
    output logic            vote_done
);
    logic [4:0] cnt_q, cnt_d;
    logic [2:0] smp_q, smp_d;
    logic [4:0] spb, sf, sm;

    // sample numbers depend on speed mode
    assign spb = dbl ? SPB_DOUBLE : SPB_NORMAL;
    assign sf  = dbl ? SF_DOUBLE  : SF_NORMAL;
    assign sm  = dbl ? SM_DOUBLE  : SM_NORMAL;

    always_comb begin
        cnt_d = cnt_q;
        smp_d = smp_q;
        if (restart) begin
            cnt_d = 5'd2; // this tick already was sample one
        end else if (tick) begin
            if (cnt_q == sf) smp_d[0] = rxd;
            if (cnt_q == sm) smp_d[1] = rxd;
            if (cnt_q == sm + 5'd1) smp_d[2] = rxd;
            cnt_d = (cnt_q == spb) ? 5'd1 : cnt_q + 5'd1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 5'd1;
            smp_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
            smp_q <= smp_d;
        end
    end

    // majority of the three centre samples
    assign bit_val   = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2])
                     | (smp_q[1] & smp_q[2]);
    assign bit_done  = tick & ~restart & (cnt_q == spb);
    assign vote_done = tick & ~restart & (cnt_q == sm + 5'd2);
endmodule

// ### rtl/uarx_top.sv
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module uarx_top
    import uarx_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rxd,
    input  wire logic        tx_done_evt,
    output logic             rts_n_full
);
    typedef enum logic [1:0] {
        UARX_IDLE  = 2'b00,
        UARX_START = 2'b01,
        UARX_DATA  = 2'b10,
        UARX_STOP  = 2'b11
    } uarx_state_e;

    logic       rst_s1_q, rst_n_q;
    // reset release through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // control registers
    logic        afe_q, afe_d, dss_q, dss_d, txc_q, txc_d, rxen_q, rxen_d;
    logic        csz2_q, csz2_d, pen_q, pen_d, podd_q, podd_d;
    logic        tstop_q, tstop_d, rts_flow_enable_q, rts_flow_enable_d;
    logic [1:0]  cszl_q, cszl_d;
    logic [11:0] baud_q, baud_d;
    // bus phase capture
    logic        wr_q, wr_d, rd_q, rd_d;
    logic [7:0]  adr_q, adr_d;
    logic [31:0] rdat_q, rdat_d;
    // receive path
    uarx_state_e st_q, st_d;
    logic [3:0]  nbit_q, nbit_d;
    logic [9:0]  sh_q, sh_d;
    logic        par_q, par_d;
    logic [11:0] bcnt_q, bcnt_d;
    logic        tick_q, tick_d;
    logic [10:0] fifo_q [RX_DEPTH];
    logic [10:0] fifo_d [RX_DEPTH];
    logic [1:0]  cnt_q, cnt_d;
    logic        hold_q, hold_d;
    logic [10:0] hold_w_q, hold_w_d;
    logic        dor_q, dor_d, rts_q, rts_d, restart;
    logic        bit_done, bit_val, vote_done;

    logic [2:0]  csz;
    logic [3:0]  dbits;
    logic        rd_data, ftype;
    assign csz   = {csz2_q, cszl_q};
    // 0..3 select 5..8 bits, 7 selects nine
    assign dbits = (csz == CSZ_NINE) ? 4'd9 : {2'b00, csz[1:0]} + 4'd5;
    assign rd_data = rd_q && adr_q == OFS_SERIAL_DATA;

    // baud tick divider: one enable pulse per sample slot
    always_comb begin
        bcnt_d = bcnt_q;
        tick_d = 1'b0;
        if (bcnt_q == 12'h000) begin
            bcnt_d = baud_q;
            tick_d = 1'b1;
        end else begin
            bcnt_d = bcnt_q - 12'h001;
        end
    end

    uarx_sampler u_smp (
        .clk       (core_clk),
        .rst_n     (rst_n_q),
        .tick      (tick_q),
        .restart   (restart),
        .dbl       (dss_q),
        .rxd       (rxd),
        .bit_done  (bit_done),
        .bit_val   (bit_val),
        .vote_done (vote_done)
    );
    assign restart = (st_q == UARX_IDLE) && tick_q && !rxd && rxen_q;

    // receive state machine, holding register and two-entry fifo
    always_comb begin
        logic [10:0] w;
        logic        push, pop, cap;
        w      = 11'h000;
        cap    = 1'b0;
        ftype  = 1'b0;
        push   = 1'b0;
        pop    = rd_data && cnt_q != 2'd0;
        st_d   = st_q;
        nbit_d = nbit_q;
        sh_d   = sh_q;
        par_d  = par_q;
        hold_d = hold_q;
        hold_w_d = hold_w_q;
        dor_d  = dor_q;
        cnt_d  = cnt_q;
        fifo_d = fifo_q;
        case (st_q)
            UARX_IDLE: if (restart) begin
                st_d = UARX_START;
                // overrun: buffer full, one waiting and new start
                if (hold_q && cnt_q == 2'(RX_DEPTH)) dor_d = 1'b1;
            end
            UARX_START: if (bit_done) begin
                st_d   = bit_val ? UARX_IDLE : UARX_DATA;
                nbit_d = 4'd0;
                par_d  = 1'b0;
                sh_d   = 10'h000;
            end
            UARX_DATA: if (bit_done) begin
                if (nbit_q < dbits) sh_d[nbit_q] = bit_val;
                else par_d = bit_val;
                nbit_d = nbit_q + 4'd1;
                if (nbit_q + 4'd1 == dbits + {3'b000, pen_q}) st_d = UARX_STOP;
            end
            UARX_STOP: if (vote_done) begin
                st_d = UARX_IDLE;
                // frame type: ninth bit or first stop bit
                ftype = (dbits == 4'd9) ? sh_q[8] : bit_val;
                // type one is an address frame; filter sits on rx path only
                if (!afe_q || ftype) begin
                    w[8:0] = sh_q[8:0];
                    w[9]   = !bit_val;
                    w[10]  = pen_q && (^{sh_q, par_q, podd_q});
                    hold_d = 1'b1;
                    cap    = 1'b1;
                    hold_w_d = w;
                end
            end
            default: st_d = UARX_IDLE;
        endcase
        if (!rxen_q) st_d = UARX_IDLE;
        // drain the holding register into the fifo
        if (pop) begin
            fifo_d[0] = fifo_q[1];
            cnt_d = cnt_q - 2'd1;
        end
        if (hold_q && (cnt_d != 2'(RX_DEPTH))) begin
            fifo_d[cnt_d[0]] = hold_w_q;
            cnt_d  = cnt_d + 2'd1;
            hold_d = cap; // a frame caught this cycle keeps waiting
            push   = 1'b1;
            dor_d  = 1'b0;
        end
        if (!rxen_q) begin
            cnt_d  = 2'd0;
            hold_d = 1'b0;
            dor_d  = 1'b0;
        end
        // rts at the stop bit vote (sample 11 of 16, 7 of 8 in double speed) when full, low when room
        rts_d = rts_q;
        if (!rts_flow_enable_q) rts_d = 1'b0;
        else if (cnt_d != 2'(RX_DEPTH)) rts_d = 1'b0;
        else if (st_q == UARX_STOP && vote_done) rts_d = 1'b1;
        else if (push && cnt_d == 2'(RX_DEPTH)) rts_d = 1'b1;
    end

    // ahb-lite slave: zero wait, data phase capture
    always_comb begin
        afe_d = afe_q; dss_d = dss_q; rxen_d = rxen_q; csz2_d = csz2_q;
        pen_d = pen_q; podd_d = podd_q; tstop_d = tstop_q;
        cszl_d = cszl_q; rts_flow_enable_d = rts_flow_enable_q; baud_d = baud_q;
        txc_d  = txc_q;
        wr_d = hsel && hready && htrans[1] && hwrite;
        rd_d = hsel && hready && htrans[1] && !hwrite;
        adr_d = (hsel && hready) ? haddr : adr_q;
        rdat_d = 32'h0;
        if (wr_q) begin
            case (adr_q)
                OFS_CTRL_STATUS_A: begin
                    afe_d = hwdata[AFE_BIT];
                    dss_d = hwdata[DSS_BIT];
                    if (hwdata[TXC_BIT]) txc_d = 1'b0;
                end
                OFS_CTRL_B: begin
                    rxen_d = hwdata[RXEN_BIT];
                    csz2_d = hwdata[CSZ2_BIT];
                end
                OFS_CTRL_C: begin
                    pen_d   = hwdata[PAR_EN_BIT];
                    podd_d  = hwdata[PAR_ODD_BIT];
                    tstop_d = hwdata[TWO_STOP_BIT];
                    cszl_d  = hwdata[CSZ_LO_BIT +: 2];
                end
                OFS_CTRL_STATUS_D: rts_flow_enable_d = hwdata[RTS_FLOW_ENABLE_BIT];
                OFS_BAUD_DIVISOR:  baud_d  = hwdata[11:0];
                default: ;
            endcase
        end
        if (tx_done_evt) txc_d = 1'b1; // set wins over clear
        if (rd_d) begin
            case (haddr)
                OFS_CTRL_STATUS_A: begin
                    rdat_d[RXC_BIT] = cnt_q != 2'd0;
                    rdat_d[TXC_BIT] = txc_q;
                    rdat_d[FE_BIT]  = fifo_q[0][9] && cnt_q != 2'd0;
                    rdat_d[DOR_BIT] = dor_q;
                    rdat_d[PE_BIT]  = fifo_q[0][10] && cnt_q != 2'd0;
                    rdat_d[DSS_BIT] = dss_q;
                    rdat_d[AFE_BIT] = afe_q;
                end
                OFS_CTRL_B: begin
                    rdat_d[RXEN_BIT] = rxen_q;
                    rdat_d[CSZ2_BIT] = csz2_q;
                    rdat_d[RX9_BIT]  = fifo_q[0][8];
                end
                OFS_CTRL_C: rdat_d[5:1] = {pen_q, podd_q, tstop_q, cszl_q};
                OFS_CTRL_STATUS_D: rdat_d[RTS_FLOW_ENABLE_BIT] = rts_flow_enable_q;
                OFS_SERIAL_DATA:   rdat_d[7:0] = fifo_q[0][7:0];
                OFS_BAUD_DIVISOR:  rdat_d[11:0] = baud_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            {afe_q, dss_q, txc_q, rxen_q, csz2_q} <= 5'h00;
            {pen_q, podd_q, tstop_q, rts_flow_enable_q} <= 4'h0;
            cszl_q <= 2'h0;
            baud_q <= BAUD_RESET;
            {wr_q, rd_q} <= 2'h0;
            adr_q  <= 8'h00;
            rdat_q <= 32'h0;
            st_q   <= UARX_IDLE;
            nbit_q <= 4'd0;
            sh_q   <= 10'h000;
            par_q  <= 1'b0;
            bcnt_q <= 12'h000;
            tick_q <= 1'b0;
            fifo_q <= '{default: 11'h000};
            cnt_q  <= 2'd0;
            hold_q <= 1'b0;
            hold_w_q <= 11'h000;
            dor_q  <= 1'b0;
            rts_q  <= 1'b0;
        end else begin
            {afe_q, dss_q, txc_q, rxen_q, csz2_q} <=
                {afe_d, dss_d, txc_d, rxen_d, csz2_d};
            {pen_q, podd_q, tstop_q, rts_flow_enable_q} <=
                {pen_d, podd_d, tstop_d, rts_flow_enable_d};
            cszl_q <= cszl_d;
            baud_q <= baud_d;
            {wr_q, rd_q} <= {wr_d, rd_d};
            adr_q  <= adr_d;
            rdat_q <= rdat_d;
            st_q   <= st_d;
            nbit_q <= nbit_d;
            sh_q   <= sh_d;
            par_q  <= par_d;
            bcnt_q <= bcnt_d;
            tick_q <= tick_d;
            fifo_q <= fifo_d;
            cnt_q  <= cnt_d;
            hold_q <= hold_d;
            hold_w_q <= hold_w_d;
            dor_q  <= dor_d;
            rts_q  <= rts_d;
        end
    end

    assign hrdata     = rdat_q;
    assign hreadyout  = rst_n_q;
    assign hresp      = 1'b0;
    assign rts_n_full = rts_q;

    rts_off_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        !rts_flow_enable_q |=> !rts_q) else $error("rts set while disabled");
    rts_room_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        rts_q |-> cnt_q == 2'(RX_DEPTH)) else $error("rts with room");
    cnt_max_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        cnt_q <= 2'(RX_DEPTH)) else $error("fifo overfilled");
    filter_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        (st_q == UARX_STOP && vote_done && afe_q && dbits == 4'd9
         && !sh_q[8]) |=> !hold_q || $stable(hold_w_q))
        else $error("data frame kept while filtering");
    flush_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        !rxen_q |=> cnt_q == 2'd0) else $error("no flush");
    txc_set_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        tx_done_evt |=> txc_q) else $error("tx flag lost");
    data_len_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        st_q == UARX_DATA |-> nbit_q <= 4'd10) else $error("long frame");
    stop_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        (st_q == UARX_STOP && vote_done) |=> st_q == UARX_IDLE)
        else $error("stop not ended");
endmodule
